// *** hw/rft_config.v ***
// Register bank for pin-0 output routing and RX FIFO threshold settings.
// Assumes an SPI byte front end that presents decoded header and data bytes
// synchronous to clk, and a FIFO that reports its byte count.
`timescale 1ns/1ps
`include "rft_regs.vh"

// Functional notes
// - Bit 6 of pin-0 config inverts the routed pin signal; resets zero.
// - Bits 5:0 select the pin-0 source; reset 63 gives crystal clock over 192.
// - Wake applies tuning 0x31/0x88 when keep bit clear, 0x35/0x81 when set.
// - Wake tuning values stay inside analogue path; test register reads unaffected.
// - Bits 5:4 choose close-in attenuation 0, 6, 12 or 18 dB; reset 00.
// - Bits 3:0 give threshold 4*(n+1) bytes; reset 7 means 32 bytes.
// - Threshold condition compares FIFO byte count with selected threshold.
module rft_config #(
   parameter CNT_W = 7, // Width of FIFO byte count
   parameter SRC_N = 64 // Number of selectable pin sources
) (
   clk, // 100 MHz clock
   resetn, // Async active-low reset
   spi_hdr_valid, // Header byte strobe
   spi_hdr, // Header byte: R/W, burst, address
   spi_wr_valid, // Write data byte strobe
   spi_wr_data, // Write data byte
   spi_rd_req, // Read data byte request
   spi_rd_data, // Read data byte
   spi_rd_valid, // Read data ready pulse
   pin_sources, // Internal signals selectable for pin 0
   xosc_clk_div, // Crystal clock divided down
   wake_pulse, // Pulse on wake from sleep
   fifo_count, // RX FIFO byte count
   gen_out_pin0, // Pin 0 level
   atten_code, // Close-in attenuation code
   tuning_word_one, // Analogue-side tuning word one
   tuning_word_two, // Analogue-side tuning word two
   fill_level_hit // Threshold condition
);
   input wire clk;
   input wire resetn;
   input wire spi_hdr_valid;
   input wire [7:0] spi_hdr;
   input wire spi_wr_valid;
   input wire [7:0] spi_wr_data;
   input wire spi_rd_req;
   output reg [7:0] spi_rd_data;
   output reg spi_rd_valid;
   input wire [SRC_N-1:0] pin_sources;
   input wire xosc_clk_div;
   input wire wake_pulse;
   input wire [CNT_W-1:0] fifo_count;
   output reg gen_out_pin0;
   output reg [1:0] atten_code;
   output reg [7:0] tuning_word_one;
   output reg [7:0] tuning_word_two;
   output reg fill_level_hit;

   // ==================================================
   // Reset synchroniser
   reg rst_s1_r;
   reg rst_s2_r;
   wire rst_n;

   // Release through two flops so no flop leaves reset on a ragged edge
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_s1_r <= 1'b0;
         rst_s2_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_s2_r <= rst_s1_r;
      end
   end
   assign rst_n = rst_s2_r;

   // ==================================================
   // Access decode
   reg [5:0] addr_r;
   reg burst_r;
   reg [7:0] pin0_output_config_r;
   reg [7:0] rx_fifo_threshold_config_r;
   reg [5:0] addr_nxt;
   reg [7:0] rd_nxt;
   wire [5:0] hdr_addr_w;

   // Only the address and burst fields of the header matter; direction comes from the strobes
   assign hdr_addr_w = spi_hdr[`RFT_HDR_ADDR_HI:`RFT_HDR_ADDR_LO];

   // Burst steps through the address, so a two-byte burst covers both registers
   always @* begin
      addr_nxt = addr_r;
      if (spi_hdr_valid)
         addr_nxt = hdr_addr_w;
      else if (burst_r && (spi_wr_valid || spi_rd_req))
         addr_nxt = addr_r + `RFT_ADDR_STEP;
   end

   // Read mux; other addresses belong to other banks and read zero here
   always @* begin
      rd_nxt = 8'h00;
      case (addr_r)
         `RFT_ADDR_PIN0_CFG: rd_nxt = pin0_output_config_r;
         `RFT_ADDR_THR_CFG: rd_nxt = rx_fifo_threshold_config_r;
         // Tuning word registers live elsewhere; wake values never show here
         default: rd_nxt = 8'h00;
      endcase
   end

   // Write enables, one per register; other addresses are ignored, not flagged
   wire wr_pin0_w;
   wire wr_thr_w;

   assign wr_pin0_w = spi_wr_valid && (addr_r == `RFT_ADDR_PIN0_CFG);
   assign wr_thr_w = spi_wr_valid && (addr_r == `RFT_ADDR_THR_CFG);

   // Header capture; the burst flag lives until the next header
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_r <= 6'h00;
         burst_r <= 1'b0;
      end else begin
         addr_r <= addr_nxt;
         if (spi_hdr_valid)
            burst_r <= spi_hdr[`RFT_ACC_BURST_BIT];
      end
   end

   // Register writes; bit 7 is stored as written, the host owns its value
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin0_output_config_r <= `RFT_RST_PIN0_CFG;
         rx_fifo_threshold_config_r <= `RFT_RST_THR_CFG;
      end else begin
         if (wr_pin0_w)
            pin0_output_config_r <= spi_wr_data;
         if (wr_thr_w)
            rx_fifo_threshold_config_r <= spi_wr_data;
      end
   end

   // Read return; data holds until the next read so a slow host can still take it
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         spi_rd_data <= 8'h00;
         spi_rd_valid <= 1'b0;
      end else begin
         spi_rd_valid <= spi_rd_req;
         if (spi_rd_req)
            spi_rd_data <= rd_nxt;
      end
   end

   // ==================================================
   // Pin 0 routing and threshold compare
   // One spare bit on the compare width so neither side is ever cut
   localparam CMP_W = ((CNT_W > 8) ? CNT_W : 8) + 1;
   wire [5:0] sel_w;
   wire inv_w;
   wire src_w;
   wire [3:0] lim_code_w;
   wire [7:0] lim_bytes_w;
   wire [CMP_W-1:0] count_ext_w;
   wire [CMP_W-1:0] lim_ext_w;

   // Field slices of the two registers
   assign sel_w = pin0_output_config_r[`RFT_SEL_HI:`RFT_SEL_LO];
   assign inv_w = pin0_output_config_r[`RFT_INV_BIT];
   assign lim_code_w = rx_fifo_threshold_config_r[`RFT_LIM_HI:`RFT_LIM_LO];
   // Code 63 is the divided crystal clock; index the bus otherwise
   assign src_w = (sel_w == `RFT_SEL_XOSC_DIV) ? xosc_clk_div : pin_sources[sel_w];
   // Threshold is 4*(n+1) bytes, so 4 to 64; the step is added after the shift
   assign lim_bytes_w = {2'b00, lim_code_w, 2'b00} + `RFT_LIM_STEP;
   // Zero-extend both sides so a wider byte count still compares correctly
   assign count_ext_w = {{(CMP_W-CNT_W){1'b0}}, fifo_count};
   assign lim_ext_w = {{(CMP_W-8){1'b0}}, lim_bytes_w};

   // Output flops; pin lags its source by one cycle
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gen_out_pin0 <= 1'b0;
         atten_code <= 2'b00;
         fill_level_hit <= 1'b0;
      end else begin
         gen_out_pin0 <= src_w ^ inv_w;
         atten_code <= rx_fifo_threshold_config_r[`RFT_ATT_HI:`RFT_ATT_LO];
         fill_level_hit <= (count_ext_w >= lim_ext_w);
      end
   end

   // ==================================================
   // Wake-up tuning words, analogue side only, never on the read path
   reg [7:0] tw_one_nxt;
   reg [7:0] tw_two_nxt;
   wire keep_w;

   assign keep_w = rx_fifo_threshold_config_r[`RFT_KEEP_BIT];

   // Words move only on a wake pulse; the keep bit is read at that edge
   always @* begin
      tw_one_nxt = tuning_word_one;
      tw_two_nxt = tuning_word_two;
      if (wake_pulse && keep_w) begin
         tw_one_nxt = `RFT_TW1_SET;
         tw_two_nxt = `RFT_TW2_SET;
      end else if (wake_pulse) begin
         tw_one_nxt = `RFT_TW1_CLR;
         tw_two_nxt = `RFT_TW2_CLR;
      end
   end

   // Reset matches the keep-clear pair, as after a cold start
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tuning_word_one <= `RFT_TW1_CLR;
         tuning_word_two <= `RFT_TW2_CLR;
      end else begin
         tuning_word_one <= tw_one_nxt;
         tuning_word_two <= tw_two_nxt;
      end
   end
endmodule

// *** hw/rft_regs.vh ***
// Register map and field layout of the pin-0 and RX FIFO threshold registers.
// Assumes it is included by bare name from the register bank module.
`ifndef RFT_REGS_VH
`define RFT_REGS_VH

// ==================================================
// Addresses and access modes
`define RFT_ADDR_PIN0_CFG 6'h02
`define RFT_ADDR_THR_CFG 6'h03
`define RFT_ACC_BURST_BIT 6
`define RFT_ACC_READ_BIT 7
`define RFT_HDR_ADDR_HI 5
`define RFT_HDR_ADDR_LO 0
`define RFT_ADDR_STEP 6'h01

// ==================================================
// Reset values
`define RFT_RST_PIN0_CFG 8'h3F
`define RFT_RST_THR_CFG 8'h07

// ==================================================
// Field positions
`define RFT_VENDOR_BIT 7
`define RFT_INV_BIT 6
`define RFT_SEL_HI 5
`define RFT_SEL_LO 0
`define RFT_KEEP_BIT 6
`define RFT_ATT_HI 5
`define RFT_ATT_LO 4
`define RFT_LIM_HI 3
`define RFT_LIM_LO 0
`define RFT_LIM_STEP 8'h04

// ==================================================
// Wake-up tuning words
`define RFT_TW1_CLR 8'h31
`define RFT_TW2_CLR 8'h88
`define RFT_TW1_SET 8'h35
`define RFT_TW2_SET 8'h81

// Clock-out select code (crystal clock divided by 192)
`define RFT_SEL_XOSC_DIV 6'h3F
`define RFT_XOSC_DIV 8'd192

`endif

// *** tb/rft_config_props.sv ***
// Port-level checks for the pin-0 and FIFO threshold bank.
// Assumes it is bound onto rft_config.
`timescale 1ns/1ps
module rft_config_props #(parameter CNT_W = 7, parameter SRC_N = 64) (
   input wire clk, // Clock
   input wire resetn, // Async reset
   input wire spi_wr_valid, // Write strobe
   input wire spi_rd_req, // Read request
   input wire [7:0] spi_rd_data, // Read data
   input wire spi_rd_valid, // Read ready
   input wire wake_pulse, // Wake
   input wire [CNT_W-1:0] fifo_count, // Count
   input wire [1:0] atten_code, // Attenuation
   input wire [7:0] tuning_word_one, // Tuning one
   input wire [7:0] tuning_word_two, // Tuning two
   input wire fill_level_hit // Threshold
);
   // ====
   // Inner reset lags release by two edges, so wait it out
   reg [1:0] up_r;
   always @(posedge clk or negedge resetn) begin
      if (!resetn) up_r <= 2'h0;
      else if (up_r != 2'h3) up_r <= up_r + 2'h1;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn || up_r != 2'h3);
   // ====
   // Properties
   rd_answer_a: assert property (spi_rd_req |=> spi_rd_valid) else $error("no read answer");
   rd_hold_a: assert property (!spi_rd_valid |-> $stable(spi_rd_data)) else $error("data moved");
   tw_pair_a: assert property ((tuning_word_one == 8'h31 && tuning_word_two == 8'h88)
      || (tuning_word_one == 8'h35 && tuning_word_two == 8'h81)) else $error("bad pair");
   tw_wake_a: assert property ($changed(tuning_word_one) |-> $past(wake_pulse)) else $error("tw1");
   tw_quiet_a: assert property (!wake_pulse |=> $stable(tuning_word_two)) else $error("tw2");
   hit_full_a: assert property (fifo_count >= 64 |=> fill_level_hit) else $error("no hit");
   hit_low_a: assert property (fifo_count < 4 |=> !fill_level_hit) else $error("false hit");
   atten_wr_a: assert property ($changed(atten_code) |-> $past(spi_wr_valid, 2)) else $error("att");
   cover property (wake_pulse);
   cover property ($rose(fill_level_hit));
   cover property (spi_rd_valid);
   cover property (spi_rd_valid && $past(spi_rd_valid));
endmodule
bind rft_config rft_config_props #(.CNT_W(CNT_W), .SRC_N(SRC_N)) u_props (.clk(clk),
   .resetn(resetn), .spi_wr_valid(spi_wr_valid), .spi_rd_req(spi_rd_req),
   .spi_rd_data(spi_rd_data), .spi_rd_valid(spi_rd_valid), .wake_pulse(wake_pulse),
   .fifo_count(fifo_count), .atten_code(atten_code), .tuning_word_one(tuning_word_one),
   .tuning_word_two(tuning_word_two), .fill_level_hit(fill_level_hit));

// *** tb/rft_host.sv ***
// Host model driving the register bank's SPI byte front end.
// Assumes the bank's clock; the bench calls its tasks.
`timescale 1ns/1ps
module rft_host (
   input wire clk, // Clock
   output reg hdr_v = 1'b0, // Header strobe
   output reg [7:0] hdr = 8'h00, // Header byte
   output reg wr_v = 1'b0, // Write strobe
   output reg [7:0] wd = 8'h00, // Write data
   output reg rd_q = 1'b0, // Read request
   input wire [7:0] rdd, // Read data
   input wire rv // Read data valid
);
   // ====
   // One single-byte transfer; released lines flip so stale data never looks valid
   // Read data is taken at the edge that sees valid high, then we step off that edge
   task xf(input [7:0] h, input [7:0] d, output [7:0] q);
      begin
         q = 8'h00;
         @(posedge clk) #1 hdr_v = 1'b1;
         hdr = h;
         @(posedge clk) #1 hdr_v = 1'b0;
         hdr = ~h;
         rd_q = h[7];
         wr_v = !h[7];
         wd = d;
         @(posedge clk) #1 rd_q = 1'b0;
         wr_v = 1'b0;
         wd = ~d;
         if (h[7]) begin
            @(posedge clk);
            q = rv ? rdd : 8'hXX;
            #1;
         end
      end
   endtask
   // Two-byte burst; the strobe stays up across both bytes
   task xb(input [7:0] h, input [7:0] d0, input [7:0] d1, output [7:0] q0,
      output [7:0] q1);
      begin
         @(posedge clk) #1 hdr_v = 1'b1;
         hdr = h;
         @(posedge clk) #1 hdr_v = 1'b0;
         hdr = ~h;
         rd_q = h[7];
         wr_v = !h[7];
         wd = d0;
         @(posedge clk) #1 wd = d1;
         @(posedge clk);
         q0 = rv ? rdd : 8'hXX;
         #1 rd_q = 1'b0;
         wr_v = 1'b0;
         wd = ~d1;
         @(posedge clk);
         q1 = rv ? rdd : 8'hXX;
         #1;
      end
   endtask
endmodule

// *** tb/tb_rft_config.sv ***
// Bench for rft_config with a host model on the SPI byte side.
// Assumes the design and host model are compiled first.
`timescale 1ns/1ps
module tb_rft_config;
   reg clk = 1'b0;
   reg resetn = 1'b0;
   reg [63:0] src = 64'h0;
   reg xo = 1'b0;
   reg wake = 1'b0;
   reg [6:0] cnt = 7'h00;
   wire hv, wv, rq, rv, pin, hit;
   wire [7:0] hd, wd, rdd, tw1, tw2;
   wire [1:0] att;
   reg [7:0] q;
   integer fail_count = 0;
   integer num_checks = 0;
   integer cyc = 0;
   integer n;
   rft_config u_dut (.clk(clk), .resetn(resetn), .spi_hdr_valid(hv), .spi_hdr(hd),
      .spi_wr_valid(wv), .spi_wr_data(wd), .spi_rd_req(rq), .spi_rd_data(rdd),
      .spi_rd_valid(rv), .pin_sources(src), .xosc_clk_div(xo), .wake_pulse(wake),
      .fifo_count(cnt), .gen_out_pin0(pin), .atten_code(att), .tuning_word_one(tw1),
      .tuning_word_two(tw2), .fill_level_hit(hit));
   rft_host u_host (.clk(clk), .hdr_v(hv), .hdr(hd), .wr_v(wv), .wd(wd), .rd_q(rq),
      .rdd(rdd), .rv(rv));
   // ====
   // Clock and hang guard
   initial forever #5 clk = ~clk;
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 5000) begin
         fail_count = fail_count + 1;
         summarize;
      end
   end
   task chk(input [7:0] got, input [7:0] exp);
      begin
         num_checks = num_checks + 1;
         if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("BAD %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task summarize;
      begin
         $display("checks %0d errors %0d", num_checks, fail_count);
         if (fail_count == 0 && num_checks > 0) $display("No errors found");
         else $display("Errors were found");
         $finish;
      end
   endtask
   // Outputs lag their register by one edge
   task settle;
      begin
         repeat (2) @(posedge clk);
         #1;
      end
   endtask
   task pulse;
      begin
         @(posedge clk) #1 wake = 1'b1;
         @(posedge clk) #1 wake = 1'b0;
         settle;
      end
   endtask
   // ====
   // Scenarios
   task t_pin;
      begin
         u_host.xf(8'h82, 8'h00, q);
         chk(q, 8'h3F);
         xo = 1'b1;
         settle;
         chk({7'h00, pin}, 8'h01);
         u_host.xf(8'h02, 8'h7F, q);
         settle;
         chk({7'h00, pin}, 8'h00);
         src = 64'h20;
         u_host.xf(8'h02, 8'h05, q);
         settle;
         chk({7'h00, pin}, 8'h01);
      end
   endtask
   task t_thr;
      begin
         u_host.xf(8'h83, 8'h00, q);
         chk(q, 8'h07);
         for (n = 0; n < 16; n = n + 1) begin
            u_host.xf(8'h03, {2'b00, n[1:0], n[3:0]}, q);
            cnt = 7'(4 * n + 3);
            settle;
            chk({7'h00, hit}, 8'h00);
            chk({6'h00, att}, {6'h00, n[1:0]});
            cnt = cnt + 7'h01;
            settle;
            chk({7'h00, hit}, 8'h01);
         end
         cnt = 7'h00;
         settle;
         chk({7'h00, hit}, 8'h00);
      end
   endtask
   task t_wake;
      begin
         u_host.xf(8'h03, 8'h47, q);
         pulse;
         chk(tw1, 8'h35);
         chk(tw2, 8'h81);
         u_host.xf(8'h83, 8'h00, q);
         chk(q, 8'h47);
         u_host.xf(8'h03, 8'h07, q);
         pulse;
         chk(tw1, 8'h31);
         chk(tw2, 8'h88);
         u_host.xf(8'hAC, 8'h00, q);
         chk(q, 8'h00);
      end
   endtask
   // Burst write then burst read across both registers
   task t_burst;
      reg [7:0] q1;
      begin
         u_host.xb(8'h42, 8'h45, 8'h2A, q, q1);
         u_host.xb(8'hC2, 8'h00, 8'h00, q, q1);
         chk(q, 8'h45);
         chk(q1, 8'h2A);
         chk({7'h00, pin}, 8'h00);
         chk({6'h00, att}, 8'h02);
      end
   endtask
   // Reset in mid-run brings registers and tuning words back
   task t_rst;
      begin
         u_host.xf(8'h02, 8'hC5, q);
         u_host.xf(8'h03, 8'h5F, q);
         pulse;
         resetn = 1'b0;
         repeat (2) @(posedge clk);
         #1 resetn = 1'b1;
         repeat (3) @(posedge clk);
         #1;
         chk(tw1, 8'h31);
         chk(tw2, 8'h88);
         chk({6'h00, att}, 8'h00);
         chk({7'h00, pin}, 8'h01);
         u_host.xf(8'h82, 8'h00, q);
         chk(q, 8'h3F);
         u_host.xf(8'h83, 8'h00, q);
         chk(q, 8'h07);
      end
   endtask
   initial begin
      repeat (6) @(posedge clk);
      #1 resetn = 1'b1;
      repeat (3) @(posedge clk);
      t_pin;
      t_thr;
      t_burst;
      t_wake;
      t_rst;
      summarize;
   end
endmodule
